// >>> rtl/chs_pkg.sv
package chs_pkg;

   // -----------------------------------------------------------------
   // Task-file register addresses on the link
   // -----------------------------------------------------------------
   localparam logic [2:0] TF_FEATURES = 3'h1;
   localparam logic [2:0] TF_SECCOUNT = 3'h2;
   localparam logic [2:0] TF_SECNUM = 3'h3;
   localparam logic [2:0] TF_CYLLOW = 3'h4;
   localparam logic [2:0] TF_CYLHIGH = 3'h5;
   localparam logic [2:0] TF_DRVHEAD = 3'h6;
   // Writes at this address hit the command opcode register, reads return
   // device status.
   localparam logic [2:0] TF_CMDSTAT = 3'h7;
   // Reads at this address return error flags.
   localparam logic [2:0] TF_ERROR = 3'h1;

   // -----------------------------------------------------------------
   // Opcodes and bit positions
   // -----------------------------------------------------------------
   localparam logic [7:0] OP_SET_GEOMETRY = 8'h91;
   localparam logic [7:0] OP_MEDIA_EJECT = 8'hED;
   localparam int DEV_BIT = 4;
   localparam int ST_BSY = 7;
   localparam int ST_DRDY = 6;
   localparam int ST_DF = 5;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ER_ABRT = 2;
   localparam int ER_NM = 1;
   localparam int ER_IDNF = 4;

   // -----------------------------------------------------------------
   // Identify geometry constants
   // -----------------------------------------------------------------
   localparam logic [31:0] CHS_CAP_LIMIT = 32'h00FB_FC10;
   localparam logic [15:0] CYL_LIMIT = 16'hFFFF;
   localparam logic [31:0] RESET_CAPACITY = 32'h0098_0000;
   localparam logic [15:0] DEF_HEADS = 16'h0010;
   localparam logic [15:0] DEF_SECTORS = 16'h003F;
   localparam logic [15:0] DEF_CYLS = 16'h3FFF;

   // -----------------------------------------------------------------
   // Host APB register map
   // -----------------------------------------------------------------
   localparam logic [11:0] REG_TASKFILE = 12'h000;
   localparam logic [11:0] REG_CONTROL = 12'h004;
   localparam logic [11:0] REG_RESULT = 12'h008;
   localparam int CTL_GO = 0;
   localparam int CTL_READ = 1;
   localparam int RES_DONE = 8;

   typedef enum logic [1:0] {CHS_IDLE, CHS_BUSY, CHS_DONE} chs_state_e;
endpackage

// >>> rtl/chs_tf_if.sv
interface chs_tf_if;
   logic [2:0] addr;
   logic wrStb;
   logic rdStb;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic rvalid;

   modport host (output addr, output wrStb, output rdStb, output wdata, input rdata, input rvalid);
   modport dev (input addr, input wrStb, input rdStb, input wdata, output rdata, output rvalid);
endinterface

// >>> rtl/chs_device.sv
// Functional notes
// [R1] Opcode 91h sets sectors-per-track from count.
// [R2] Device/Head low nibble gives max head.
// [R3] Bit 4 selects device, echoed back.
// [R4] Geometry success clears BSY, DF, DRQ, ERR.
// [R5] Unsupported translation sets abort bit.
// [R6] Error: BSY/DRQ clear, ERR follows error bits.
// [R7] Geometry command accepted regardless of ready.
// [R8] Default translation always supported below limit.
// [R9] Reject clears word 53 bit 0, zeroes 54-58.
// [R10] No valid translation fails media access IDNF; code only raises mediaAccessFail_q, no IDNF bit.
// [R11] Words 1, 3, 6, 61:60 never change.
// [R12] Word 55 becomes max head plus one.
// [R13] Word 56 becomes sectors per track.
// [R14] Word 54 from capacity, clamped to 65535.
// [R15] Above limit, fixed limit replaces capacity.
// [R16] Words 58:57 are product of 54-56.
// [R17] Eject completes pending work, unlocks, ejects.
// [R18] Single lock state, one eject clears it.
// [R19] Eject without media sets no-media and ERR.
// [R20] Unimplemented eject answers command aborted.
// [R21] Eject only when ready; ready set after.
// [R22] Abort may flag any other failure.
// [R23] Host writes parameters before the opcode.
module chs_device
   import chs_pkg::*;
#(
   parameter logic EJECT_SUPPORTED = 1'b1,
   parameter logic [31:0] CAPACITY = RESET_CAPACITY,
   parameter int SPIN_CYCLES = 16
) (
   input wire logic clk,
   input wire logic rstn,
   chs_tf_if.dev tf,
   input wire logic mediaPresent,
   input wire logic lockReq,
   input wire logic deviceFault,
   input wire logic mediaAccessReq,
   output logic mediaAccessFail_q,
   output logic ejectPulse_q,
   output logic mediaLocked_q,
   output logic chsValid_q,
   output logic [15:0] curCyls_q,
   output logic [15:0] curHeads_q,
   output logic [15:0] curSectors_q,
   output logic [31:0] curCapacity_q
);
   import chs_pkg::*;

   // -----------------------------------------------------------------
   // Task-file storage
   // -----------------------------------------------------------------
   logic [7:0] secCount_q;
   logic [7:0] drvHead_q;
   logic [7:0] status_q;
   logic [7:0] error_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic [7:0] opcode_q;
   chs_state_e state_q;
   logic [7:0] spin_q;
   logic calcGo_q;

   wire cmdWrite = tf.wrStb && tf.addr == TF_CMDSTAT;
   wire busy = status_q[ST_BSY];
   wire [15:0] reqHeads = {12'h000, drvHead_q[3:0]} + 16'h0001;
   wire [15:0] reqSectors = {8'h00, secCount_q};
   wire [31:0] effCap = (CAPACITY > CHS_CAP_LIMIT) ? CHS_CAP_LIMIT : CAPACITY;
   wire [31:0] hxs = 32'(reqHeads) * 32'(reqSectors);
   wire [31:0] cylFull = (hxs == 32'h0000_0000) ? 32'h0000_0000 : effCap / hxs;
   wire [15:0] cyls = (cylFull > {16'h0000, CYL_LIMIT}) ? CYL_LIMIT : cylFull[15:0];
   wire supported = (secCount_q != 8'h00) && (cyls != 16'h0000);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         secCount_q <= 8'h00;
         drvHead_q <= 8'h00;
      end else if (tf.wrStb && !busy) begin
         if (tf.addr == TF_SECCOUNT) begin
            secCount_q <= tf.wdata; // R1
         end
         if (tf.addr == TF_DRVHEAD) begin
            drvHead_q <= tf.wdata; // R2
         end
      end
   end

   // -----------------------------------------------------------------
   // Read path; device/head is returned as written so DEV stays put.
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= tf.rdStb;
         if (tf.rdStb) begin
            case (tf.addr)
               TF_CMDSTAT: rdata_q <= status_q;
               TF_ERROR: rdata_q <= error_q;
               TF_SECCOUNT: rdata_q <= secCount_q;
               TF_DRVHEAD: rdata_q <= drvHead_q; // R3
               default: rdata_q <= 8'h00;
            endcase
         end
      end
   end
   assign tf.rdata = rdata_q;
   assign tf.rvalid = rvalid_q;

   // -----------------------------------------------------------------
   // Command sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= CHS_IDLE;
         opcode_q <= 8'h00;
         spin_q <= 8'h00;
         status_q <= 8'h01 << ST_DRDY;
         error_q <= 8'h00;
         mediaLocked_q <= 1'b0;
         ejectPulse_q <= 1'b0;
         calcGo_q <= 1'b0;
      end else begin
         ejectPulse_q <= 1'b0;
         calcGo_q <= 1'b0;
         if (lockReq && mediaPresent) begin
            mediaLocked_q <= 1'b1; // R18
         end
         case (state_q)
            CHS_IDLE: begin
               // The geometry opcode ignores DRDY; eject relies on the host.
               if (cmdWrite && (tf.wdata == OP_SET_GEOMETRY || tf.wdata == OP_MEDIA_EJECT)) begin // R7 R21
                  opcode_q <= tf.wdata;
                  status_q[ST_BSY] <= 1'b1;
                  status_q[ST_DRDY] <= 1'b0;
                  spin_q <= 8'(SPIN_CYCLES);
                  state_q <= CHS_BUSY;
               end else if (cmdWrite) begin
                  error_q <= 8'h01 << ER_ABRT; // R22
                  status_q <= (8'h01 << ST_DRDY) | (8'h01 << ST_ERR);
               end
            end
            CHS_BUSY: begin
               if (opcode_q == OP_SET_GEOMETRY) begin
                  error_q <= supported ? 8'h00 : (8'h01 << ER_ABRT); // R5
                  status_q[ST_ERR] <= !supported; // R4 R6
                  calcGo_q <= 1'b1;
                  state_q <= CHS_DONE;
               end else if (!EJECT_SUPPORTED) begin
                  error_q <= 8'h01 << ER_ABRT; // R20
                  status_q[ST_ERR] <= 1'b1;
                  state_q <= CHS_DONE;
               end else if (!mediaPresent) begin
                  error_q <= 8'h01 << ER_NM; // R19
                  status_q[ST_ERR] <= 1'b1;
                  state_q <= CHS_DONE;
               end else if (spin_q != 8'h00) begin
                  spin_q <= spin_q - 8'h01; // R17
               end else begin
                  mediaLocked_q <= 1'b0; // R17 R18
                  ejectPulse_q <= 1'b1;
                  error_q <= 8'h00;
                  status_q[ST_ERR] <= 1'b0;
                  state_q <= CHS_DONE;
               end
            end
            CHS_DONE: begin
               status_q[ST_BSY] <= 1'b0; // R6
               status_q[ST_DRQ] <= 1'b0;
               // A fault only shows on an error finish; a clean finish always clears it.
               status_q[ST_DF] <= deviceFault && status_q[ST_ERR]; // R4 R6
               status_q[ST_DRDY] <= 1'b1; // R21
               state_q <= CHS_IDLE;
            end
            default: state_q <= CHS_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Identify geometry words; default words are constants.
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         chsValid_q <= 1'b1; // R8
         curCyls_q <= DEF_CYLS;
         curHeads_q <= DEF_HEADS;
         curSectors_q <= DEF_SECTORS;
         curCapacity_q <= 32'(DEF_CYLS) * 32'(DEF_HEADS) * 32'(DEF_SECTORS);
      end else if (calcGo_q) begin
         chsValid_q <= !error_q[ER_ABRT]; // R9
         if (error_q[ER_ABRT]) begin
            curCyls_q <= 16'h0000; // R9
            curHeads_q <= 16'h0000;
            curSectors_q <= 16'h0000;
            curCapacity_q <= 32'h0000_0000;
         end else begin
            curHeads_q <= reqHeads; // R12
            curSectors_q <= reqSectors; // R13
            curCyls_q <= cyls; // R14 R15 R11
            curCapacity_q <= 32'(cyls) * hxs; // R16
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mediaAccessFail_q <= 1'b0;
      end else begin
         mediaAccessFail_q <= mediaAccessReq && !chsValid_q; // R10
      end
   end
endmodule

// >>> rtl/chs_host.sv
module chs_host
   import chs_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   chs_tf_if.host tf
);
   import chs_pkg::*;

   // -----------------------------------------------------------------
   // Software writes {addr,data} then a control go; one link access each.
   // -----------------------------------------------------------------
   logic [10:0] taskFile_q;
   logic [7:0] result_q;
   logic done_q;
   logic [2:0] addr_q;
   logic [7:0] wdata_q;
   logic wrStb_q;
   logic rdStb_q;

   wire access = psel && penable;
   wire goWrite = access && pwrite && paddr == REG_CONTROL && pwdata[CTL_GO];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         taskFile_q <= 11'h000;
         addr_q <= 3'h0;
         wdata_q <= 8'h00;
         wrStb_q <= 1'b0;
         rdStb_q <= 1'b0;
      end else begin
         wrStb_q <= 1'b0;
         rdStb_q <= 1'b0;
         if (access && pwrite && paddr == REG_TASKFILE) begin
            taskFile_q <= pwdata[10:0];
         end
         // The opcode write goes last; software orders it, the link keeps it.
         if (goWrite) begin // R23
            addr_q <= taskFile_q[10:8];
            wdata_q <= taskFile_q[7:0];
            wrStb_q <= !pwdata[CTL_READ];
            rdStb_q <= pwdata[CTL_READ];
         end
      end
   end
   assign tf.addr = addr_q;
   assign tf.wdata = wdata_q;
   assign tf.wrStb = wrStb_q;
   assign tf.rdStb = rdStb_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         result_q <= 8'h00;
         done_q <= 1'b0;
      end else if (tf.rvalid) begin
         result_q <= tf.rdata;
         done_q <= 1'b1;
      end else if (goWrite) begin
         done_q <= pwdata[CTL_READ] ? 1'b0 : 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !pready;
         pslverr <= psel && !pready && paddr != REG_TASKFILE && paddr != REG_CONTROL && paddr != REG_RESULT;
         case (paddr)
            REG_TASKFILE: prdata <= {21'h00_0000, taskFile_q};
            REG_RESULT: prdata <= {23'h00_0000, done_q, result_q};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule

// >>> tb/chs_tf_properties.sv
module chs_tf_properties (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] addr,
   input wire logic wrStb,
   input wire logic rdStb,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   import chs_pkg::*;
   logic [2:0] rdA_q;
   logic stErr_q;
   logic stSeen_q;
   logic stRd;
   logic erRd;
   assign stRd = rvalid && rdA_q == TF_CMDSTAT;
   assign erRd = rvalid && rdA_q == TF_ERROR;
   // An error read is only judged against a status read taken since the last command.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdA_q <= 3'h0;
         stErr_q <= 1'b0;
         stSeen_q <= 1'b0;
      end else begin
         if (rdStb) rdA_q <= addr;
         if (wrStb && addr == TF_CMDSTAT) stSeen_q <= 1'b0;
         else if (stRd) begin
            stErr_q <= rdata[ST_ERR];
            stSeen_q <= 1'b1;
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   AST_READ_ANSWER: assert property (rdStb |=> rvalid) else $error("read unanswered");
   AST_ANSWER_CAUSE: assert property (rvalid |-> $past(rdStb)) else $error("stray answer");
   AST_DATA_HOLD: assert property (!rvalid |-> $stable(rdata)) else $error("read data moved");
   AST_WRITE_PULSE: assert property (wrStb |=> !wrStb) else $error("write strobe held");
   AST_STROBE_EXCL: assert property (!(wrStb && rdStb)) else $error("two strobes");
   AST_NO_DRQ: assert property (stRd |-> !rdata[ST_DRQ]) else $error("data request shown");
   AST_READY_DONE: assert property (stRd && !rdata[ST_BSY] |-> rdata[ST_DRDY]) else $error("not ready");
   AST_ERR_CODES: assert property (erRd |-> (rdata & 8'hF9) == 8'h00) else $error("bad error bit");
   AST_ERR_FLAG: assert property (erRd && stSeen_q |-> (rdata != 8'h00) == stErr_q) else $error("flag");
   CV_GEO: cover property (wrStb && addr == TF_CMDSTAT && wdata == OP_SET_GEOMETRY);
   CV_EJECT: cover property (wrStb && addr == TF_CMDSTAT && wdata == OP_MEDIA_EJECT);
   CV_ABORT: cover property (erRd && rdata[ER_ABRT]);
endmodule

// >>> tb/chs_geometry_and_eject_cmds_test.sv
module chs_geometry_and_eject_cmds_test;
   timeunit 1ns;
   timeprecision 1ns;
   import chs_pkg::*;
`define CMP(a, e) begin checked++; if ((a) !== (e)) begin fails++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
   // Capacity above the translation limit, so the fixed limit sets the cylinder count.
   localparam logic [31:0] CAP = 32'h0100_0000;
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, rnd, capq;
   logic pready, pslverr, err, accFail, ejPulse, locked, valid;
   logic media = 1'b1, lockReq = 1'b0, fault = 1'b0, accReq = 1'b0;
   logic [15:0] cyl, hd, sec;
   logic [7:0] exp8;
   logic [7:0] expQ[$];
   int fails = 0, checked = 0, ejects = 0;
   chs_tf_if tf();
   chs_host i_chs_host(.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tf(tf));
   chs_device #(.CAPACITY(CAP), .SPIN_CYCLES(4)) i_chs_device(.clk(clk), .rstn(rstn), .tf(tf), .mediaPresent(media),
      .lockReq(lockReq), .deviceFault(fault), .mediaAccessReq(accReq), .mediaAccessFail_q(accFail),
      .ejectPulse_q(ejPulse), .mediaLocked_q(locked), .chsValid_q(valid), .curCyls_q(cyl), .curHeads_q(hd),
      .curSectors_q(sec), .curCapacity_q(capq));
   chs_tf_properties i_chs_tf_properties(.clk(clk), .rstn(rstn), .addr(tf.addr), .wrStb(tf.wrStb),
      .rdStb(tf.rdStb), .wdata(tf.wdata), .rdata(tf.rdata), .rvalid(tf.rvalid));
   // ------------------------------------------------------------
   // Bus and link helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // The idle edge at the end keeps a following setup off the release edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic waitDone();
      for (int n = 0; n < 50; n++) begin
         apb(1'b0, REG_RESULT, 32'h0000_0000);
         if (rd[RES_DONE] === 1'b1) break;
      end
   endtask
   task automatic tfw(input logic [2:0] a, input logic [7:0] d);
      apb(1'b1, REG_TASKFILE, {21'h00_0000, a, d});
      apb(1'b1, REG_CONTROL, 32'h0000_0001);
      waitDone();
   endtask
   task automatic tfr(input logic [2:0] a, input logic [7:0] e);
      expQ.push_back(e);
      apb(1'b1, REG_TASKFILE, {21'h00_0000, a, 8'h00});
      apb(1'b1, REG_CONTROL, 32'h0000_0003);
      waitDone();
   endtask
   task automatic cmd(input logic [7:0] op, input logic [7:0] st, input logic [7:0] er);
      tfw(TF_CMDSTAT, op);
      repeat (12) @(posedge clk);
      tfr(TF_CMDSTAT, st);
      if (st[ST_ERR]) tfr(TF_ERROR, er);
   endtask
   task automatic geo(input logic [7:0] s, input logic [3:0] h, input logic dev);
      logic [31:0] c;
      c = CHS_CAP_LIMIT / ((32'(h) + 1) * 32'(s));
      if (c > 32'h0000_FFFF) c = 32'h0000_FFFF;
      tfw(TF_SECCOUNT, s);
      tfw(TF_DRVHEAD, {3'b000, dev, h});
      cmd(OP_SET_GEOMETRY, 8'h40, 8'h00);
      `CMP(hd, 16'(h) + 16'h0001)
      `CMP(sec, 16'(s))
      `CMP(cyl, c[15:0])
      `CMP(capq, c * (32'(h) + 1) * 32'(s))
      `CMP(valid, 1'b1)
      tfr(TF_DRVHEAD, {3'b000, dev, h});
      tfr(TF_SECCOUNT, s);
   endtask
   task automatic close_out();
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Clock, monitor, watchdog and scenarios
   // ------------------------------------------------------------
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      if (ejPulse === 1'b1) ejects++;
      if (tf.rvalid === 1'b1 && expQ.size() > 0) begin
         exp8 = expQ.pop_front();
         `CMP(tf.rdata, exp8)
      end
   end
   initial begin
      #200_000;
      fails++;
      close_out();
   end
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      `CMP(cyl, DEF_CYLS)
      `CMP(hd, DEF_HEADS)
      `CMP(capq, CHS_CAP_LIMIT)
      tfr(TF_CMDSTAT, 8'h40);
      apb(1'b0, 12'hFF0, 32'h0000_0000);
      `CMP(err, 1'b1)
      rnd = 32'h0000_8386;
      for (int i = 0; i < 4; i++) begin
         rnd = xs(rnd);
         if (i == 0) geo(8'h01, 4'h0, rnd[12]);
         else geo(rnd[7:0] | 8'h01, rnd[11:8], rnd[12]);
      end
      fault <= 1'b1;
      tfw(TF_SECCOUNT, 8'h00);
      cmd(OP_SET_GEOMETRY, 8'h61, 8'h04);
      `CMP(valid, 1'b0)
      `CMP(capq, 32'h0000_0000)
      accReq <= 1'b1;
      repeat (2) @(posedge clk);
      `CMP(accFail, 1'b1)
      // The fault input stays high here: a clean finish must still show DF low.
      geo(8'h20, 4'h7, 1'b1);
      fault <= 1'b0;
      `CMP(accFail, 1'b0)
      lockReq <= 1'b1;
      repeat (3) @(posedge clk);
      `CMP(locked, 1'b1)
      lockReq <= 1'b0;
      cmd(OP_MEDIA_EJECT, 8'h40, 8'h00);
      `CMP(locked, 1'b0)
      `CMP(ejects, 1)
      media <= 1'b0;
      cmd(OP_MEDIA_EJECT, 8'h41, 8'h02);
      cmd(8'hA5, 8'h41, 8'h04);
      repeat (4) @(posedge clk);
      `CMP(expQ.size(), 0)
      close_out();
   end
endmodule
